// [rtl/tdc_register_bank.sv]
// module: software visible control and status registers of the multihit tdc board
`timescale 1ns/1ps
module tdc_register_bank
	import tdc_regs_pkg::*;
#(
	parameter logic [7:0] FW_REVISION = 8'h01 // arbitrary value
)(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// module bus access
	input wire logic [7:0] baseSwitch,
	input wire logic busRead,
	input wire logic busWrite,
	input wire logic [23:0] busAddr,
	input wire logic [31:0] busWdata,
	output logic busAck,
	output logic [31:0] busRdata,
	// interrupt
	input wire logic iackReq,
	input wire logic [2:0] iackLevel,
	output logic irqRequest,
	output logic [2:0] irqLevel,
	// acquisition side
	input wire logic extTrigger,
	input wire logic trgMatch,
	input wire logic [15:0] bufferWords,
	input wire logic [15:0] eventsHeld,
	output logic triggerPulse,
	output logic moduleReset,
	output logic clearPulse,
	output logic tdcGlobalReset,
	output logic eventReset,
	output logic tdcDataBlock,
	output logic injectValid,
	output logic [31:0] injectData,
	output logic [4:0] slotPositionCode,
	output logic [7:0] blockEventCount,
	output logic [15:0] chainControl,
	output logic [15:0] outputSelect,
	// controller handshake
	input wire logic ctrlReadOk,
	input wire logic ctrlWriteOk,
	input wire logic [15:0] ctrlOpcodeIn,
	output logic ctrlOpcodeWrite,
	output logic ctrlOpcodeRead,
	output logic [15:0] ctrlOpcodeOut,
	// serial flash
	output logic flashCsN,
	output logic flashSck,
	output logic flashMosi,
	input wire logic flashMiso
);
	import tdc_regs_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] control;
		logic [7:0] relocAddr;
		logic relocSel;
		logic [2:0] irqLevel;
		logic [7:0] irqVector;
		logic [4:0] slot;
		logic [7:0] mcastBase;
		logic [15:0] mcastCtrl;
		logic [15:0] fillThr;
		logic [7:0] blockEvents;
		logic [31:0] inject;
		logic [15:0] outSel;
		logic [15:0] opcode;
		logic flashCsN;
		logic [31:0] scratchWide;
		logic [15:0] scratchNarrow;
		logic [31:0] trigCount;
		logic almostFull;
		logic irqReq;
		logic busAck;
		logic [31:0] busRdata;
		logic modReset;
		logic clear;
		logic evReset;
		logic trigPulse;
		logic injValid;
		logic opWrite;
		logic opRead;
		logic flashStart;
		logic [7:0] flashTx;
		logic flashWait;
	} bank_t;

	bank_t s_q;
	bank_t s_d;
	logic [7:0] activeBase;
	logic [15:0] off;
	logic inWindow;
	logic inMcast;

	flash_if fl ();

	// defaults shared by the hardware reset and the module reset command
	function automatic bank_t resetState();
		bank_t r;
		r = '0;
		r.control = CONTROL_RESET;
		r.irqLevel = IRQ_LEVEL_RESET;
		r.irqVector = IRQ_VECTOR_RESET;
		r.slot = SLOT_RESET;
		r.mcastBase = MCAST_BASE_RESET;
		r.fillThr = FILL_THR_RESET;
		r.blockEvents = BLOCK_EVENTS_RESET;
		r.flashCsN = FLASH_SEL_RESET;
		return r;
	endfunction

	function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
		return a == o;
	endfunction

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	always_comb begin
		activeBase = s_q.relocSel ? s_q.relocAddr : baseSwitch;
		off = busAddr[15:0];
		// only the selected base answers; the other one is dead
		inWindow = busAddr[23:16] == activeBase;
		inMcast = busWrite && (busAddr[23:16] == s_q.mcastBase);
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.busAck = 1'b0;
		s_d.modReset = 1'b0;
		s_d.clear = 1'b0;
		s_d.evReset = 1'b0;
		s_d.trigPulse = extTrigger;
		s_d.injValid = 1'b0;
		s_d.opWrite = 1'b0;
		s_d.opRead = 1'b0;
		s_d.flashStart = 1'b0;

		// level compare, so the flag follows the count both ways
		s_d.almostFull = bufferWords >= s_q.fillThr;

		if (s_q.flashWait) begin
			// bus is held until the byte has gone through the shifter
			if (fl.done) begin
				s_d.flashWait = 1'b0;
				s_d.busAck = 1'b1;
				s_d.busRdata = {24'h000000, fl.rxByte};
			end
		end else if (iackReq && (s_q.irqLevel != 3'h0) && (iackLevel == s_q.irqLevel)) begin
			s_d.busAck = 1'b1;
			s_d.busRdata = {24'h000000, s_q.irqVector};
		end else if ((busRead || busWrite) && inWindow && hit(off, OFF_MOD_RESET)) begin
			// read or write alike restores the whole bank
			s_d = resetState();
			s_d.busAck = 1'b1;
			s_d.modReset = 1'b1;
		end else if (busRead && inWindow) begin
			s_d.busAck = 1'b1;
			s_d.busRdata = 32'h00000000;
			unique case (off)
				OFF_CONTROL: s_d.busRdata = {16'h0000, s_q.control};
				OFF_STATUS: begin
					s_d.busRdata[STAT_DATA_READY_BIT] = eventsHeld != 16'h0000;
					s_d.busRdata[STAT_ALMOST_FULL_BIT] = s_q.almostFull;
					s_d.busRdata[STAT_TRG_MATCH_BIT] = trgMatch;
				end
				OFF_RELOC_ADDR: s_d.busRdata = {24'h000000, s_q.relocAddr};
				OFF_IRQ_LEVEL: s_d.busRdata = {29'h00000000, s_q.irqLevel};
				OFF_IRQ_VECTOR: s_d.busRdata = {24'h000000, s_q.irqVector};
				OFF_SLOT: s_d.busRdata = {27'h0000000, s_q.slot};
				OFF_MCAST_BASE: s_d.busRdata = {24'h000000, s_q.mcastBase};
				OFF_MCAST_CTRL: s_d.busRdata = {16'h0000, s_q.mcastCtrl};
				OFF_TRIG_COUNT: s_d.busRdata = s_q.trigCount;
				OFF_EVENTS_HELD: s_d.busRdata = {16'h0000, eventsHeld};
				OFF_FILL_THR: s_d.busRdata = {16'h0000, s_q.fillThr};
				OFF_BLOCK_EVENTS: s_d.busRdata = {24'h000000, s_q.blockEvents};
				OFF_FW_REV: s_d.busRdata = {24'h000000, FW_REVISION};
				OFF_INJECT: s_d.busRdata = s_q.inject;
				OFF_OUT_SEL: s_d.busRdata = {16'h0000, s_q.outSel};
				OFF_OPCODE: begin
					s_d.busRdata = {16'h0000, ctrlOpcodeIn};
					s_d.opRead = 1'b1;
				end
				OFF_HANDSHAKE: begin
					s_d.busRdata[HS_READ_OK_BIT] = ctrlReadOk;
					s_d.busRdata[HS_WRITE_OK_BIT] = ctrlWriteOk;
				end
				OFF_FLASH_SEL: s_d.busRdata = {31'h00000000, s_q.flashCsN};
				OFF_FLASH_DATA: begin
					// a read clocks in one byte while sending zeros
					s_d.busAck = 1'b0;
					s_d.flashStart = 1'b1;
					s_d.flashTx = 8'h00;
					s_d.flashWait = 1'b1;
				end
				OFF_SCRATCH_WIDE: s_d.busRdata = s_q.scratchWide;
				OFF_SCRATCH_NARROW: s_d.busRdata = {16'h0000, s_q.scratchNarrow};
				default: s_d.busRdata = 32'h00000000;
			endcase
		end else if (busWrite && inWindow) begin
			s_d.busAck = 1'b1;
			unique case (off)
				OFF_CONTROL: s_d.control = busWdata[15:0];
				OFF_RELOC_ADDR: s_d.relocAddr = busWdata[7:0];
				OFF_RELOC_SEL: s_d.relocSel = busWdata[0];
				OFF_IRQ_LEVEL: s_d.irqLevel = busWdata[2:0];
				OFF_IRQ_VECTOR: s_d.irqVector = busWdata[7:0];
				OFF_SLOT: s_d.slot = busWdata[4:0];
				OFF_MCAST_BASE: s_d.mcastBase = busWdata[7:0];
				OFF_MCAST_CTRL: s_d.mcastCtrl = busWdata[15:0];
				OFF_SW_CLEAR: s_d.clear = 1'b1;
				OFF_EVENT_RESET: s_d.evReset = 1'b1;
				OFF_TRIGGER: s_d.trigPulse = 1'b1;
				OFF_FILL_THR: begin
					// clamp so the threshold can always be reached
					s_d.fillThr = (busWdata[15:0] > FILL_THR_MAX) ? FILL_THR_MAX : busWdata[15:0];
				end
				OFF_BLOCK_EVENTS: s_d.blockEvents = busWdata[7:0];
				OFF_INJECT: begin
					s_d.inject = busWdata;
					s_d.injValid = s_q.control[CTRL_TEST_FIFO_BIT];
				end
				OFF_OUT_SEL: s_d.outSel = busWdata[15:0];
				OFF_OPCODE: begin
					s_d.opcode = busWdata[15:0];
					s_d.opWrite = 1'b1;
				end
				OFF_FLASH_SEL: s_d.flashCsN = busWdata[0];
				OFF_FLASH_DATA: begin
					s_d.busAck = 1'b0;
					s_d.flashStart = 1'b1;
					s_d.flashTx = busWdata[7:0];
					s_d.flashWait = 1'b1;
				end
				OFF_SCRATCH_WIDE: s_d.scratchWide = busWdata;
				OFF_SCRATCH_NARROW: s_d.scratchNarrow = busWdata[15:0];
				default: s_d.busAck = 1'b1;
			endcase
		end else if (inMcast) begin
			// broadcast cycles reach only the readout tuning registers
			s_d.busAck = 1'b1;
			unique case (off)
				OFF_FILL_THR: begin
					s_d.fillThr = (busWdata[15:0] > FILL_THR_MAX) ? FILL_THR_MAX : busWdata[15:0];
				end
				OFF_BLOCK_EVENTS: s_d.blockEvents = busWdata[7:0];
				default: s_d.busAck = 1'b1;
			endcase
		end

		// uses the level being written, so a zero level stops the request at once
		s_d.irqReq = s_d.almostFull && (s_d.irqLevel != 3'h0);

		// counter: the clear wins over a trigger in the same cycle
		if (s_d.clear || s_d.modReset) begin
			s_d.trigCount = 32'h00000000;
		end else if (s_d.trigPulse && trgMatch) begin
			s_d.trigCount = s_q.trigCount + 32'h00000001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= resetState();
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// flash shifter
	// ------------------------------------------------------------
	assign fl.start = s_q.flashStart;
	assign fl.txByte = s_q.flashTx;

	flash_shifter u_shifter (
		.ref_clk(ref_clk),
		.rst(rst),
		.req(fl.shifter),
		.flashSck(flashSck),
		.flashMosi(flashMosi),
		.flashMiso(flashMiso)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign busAck = s_q.busAck;
	assign busRdata = s_q.busRdata;
	assign irqRequest = s_q.irqReq;
	assign irqLevel = s_q.irqLevel;
	assign triggerPulse = s_q.trigPulse;
	assign moduleReset = s_q.modReset;
	assign clearPulse = s_q.clear;
	assign tdcGlobalReset = s_q.clear;
	assign eventReset = s_q.evReset;
	assign tdcDataBlock = s_q.control[CTRL_TEST_FIFO_BIT];
	assign injectValid = s_q.injValid;
	assign injectData = s_q.inject;
	assign slotPositionCode = s_q.slot;
	assign blockEventCount = s_q.blockEvents;
	assign chainControl = s_q.mcastCtrl;
	assign outputSelect = s_q.outSel;
	assign ctrlOpcodeWrite = s_q.opWrite;
	assign ctrlOpcodeRead = s_q.opRead;
	assign ctrlOpcodeOut = s_q.opcode;
	assign flashCsN = s_q.flashCsN;
endmodule

// [rtl/tdc_regs_pkg.sv]
// package: register map, field layout, reset values and timing of the tdc register bank
package tdc_regs_pkg;

	// ------------------------------------------------------------
	// register offsets (low 16 address bits, inside the base window)
	// ------------------------------------------------------------
	localparam logic [15:0] OFF_CONTROL = 16'h1000;
	localparam logic [15:0] OFF_STATUS = 16'h1002;
	localparam logic [15:0] OFF_RELOC_ADDR = 16'h1006;
	localparam logic [15:0] OFF_RELOC_SEL = 16'h1008;
	localparam logic [15:0] OFF_IRQ_LEVEL = 16'h100a;
	localparam logic [15:0] OFF_IRQ_VECTOR = 16'h100c;
	localparam logic [15:0] OFF_SLOT = 16'h100e;
	localparam logic [15:0] OFF_MCAST_BASE = 16'h1010;
	localparam logic [15:0] OFF_MCAST_CTRL = 16'h1012;
	localparam logic [15:0] OFF_MOD_RESET = 16'h1014;
	localparam logic [15:0] OFF_SW_CLEAR = 16'h1016;
	localparam logic [15:0] OFF_EVENT_RESET = 16'h1018;
	localparam logic [15:0] OFF_TRIGGER = 16'h101a;
	localparam logic [15:0] OFF_TRIG_COUNT = 16'h101c;
	localparam logic [15:0] OFF_EVENTS_HELD = 16'h1020;
	localparam logic [15:0] OFF_FILL_THR = 16'h1022;
	localparam logic [15:0] OFF_BLOCK_EVENTS = 16'h1024;
	localparam logic [15:0] OFF_FW_REV = 16'h1026;
	localparam logic [15:0] OFF_INJECT = 16'h1028;
	localparam logic [15:0] OFF_OUT_SEL = 16'h102c;
	localparam logic [15:0] OFF_OPCODE = 16'h102e;
	localparam logic [15:0] OFF_HANDSHAKE = 16'h1030;
	localparam logic [15:0] OFF_FLASH_SEL = 16'h1032;
	localparam logic [15:0] OFF_FLASH_DATA = 16'h1034;
	localparam logic [15:0] OFF_SCRATCH_WIDE = 16'h1200;
	localparam logic [15:0] OFF_SCRATCH_NARROW = 16'h1204;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_TEST_FIFO_BIT = 8;
	localparam int STAT_DATA_READY_BIT = 0;
	localparam int STAT_ALMOST_FULL_BIT = 1;
	localparam int STAT_TRG_MATCH_BIT = 3;
	localparam int HS_WRITE_OK_BIT = 0;
	localparam int HS_READ_OK_BIT = 1;

	// ------------------------------------------------------------
	// reset values and limits
	// ------------------------------------------------------------
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [2:0] IRQ_LEVEL_RESET = 3'h0;
	localparam logic [7:0] IRQ_VECTOR_RESET = 8'hdd;
	localparam logic [4:0] SLOT_RESET = 5'h1f;
	localparam logic [7:0] MCAST_BASE_RESET = 8'haa;
	localparam logic [15:0] FILL_THR_RESET = 16'h0040;
	localparam logic [15:0] FILL_THR_MAX = 16'h7fdf;
	localparam logic [7:0] BLOCK_EVENTS_RESET = 8'h00;
	localparam logic FLASH_SEL_RESET = 1'b1;

	// ------------------------------------------------------------
	// timing: serial flash clock half period
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int SCK_HALF_NS = 25;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FLASH_BITS = 8;

endpackage

// [rtl/flash_if.sv]
// interface: byte request and answer between the register bank and the flash shifter
`timescale 1ns/1ps
interface flash_if;
	logic start;
	logic [7:0] txByte;
	logic done;
	logic [7:0] rxByte;

	modport requester (output start, output txByte, input done, input rxByte);
	modport shifter (input start, input txByte, output done, output rxByte);
endinterface

// [rtl/flash_shifter.sv]
// module: shifts one byte out to and one byte in from the serial flash
`timescale 1ns/1ps
module flash_shifter
	import tdc_regs_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// byte request
	flash_if.shifter req,
	// serial pins
	output logic flashSck,
	output logic flashMosi,
	input wire logic flashMiso
);
	import tdc_regs_pkg::*;

	typedef struct packed {
		logic busy;
		logic [7:0] div;
		logic [3:0] bits;
		logic [7:0] txSh;
		logic [7:0] rxSh;
		logic sck;
		logic mosi;
		logic done;
	} shift_t;

	localparam logic [7:0] HALF_LAST = 8'(SCK_HALF_CYC - 1);
	localparam logic [3:0] BITS_LAST = 4'(FLASH_BITS - 1);

	shift_t s_q;
	shift_t s_d;

	// ------------------------------------------------------------
	// mode 0: data changes while clock low, sampled on rising edge
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (!s_q.busy) begin
			if (req.start) begin
				s_d.busy = 1'b1;
				s_d.div = 8'h00;
				s_d.bits = 4'h0;
				s_d.txSh = {req.txByte[6:0], 1'b0};
				s_d.mosi = req.txByte[7];
				s_d.sck = 1'b0;
			end
		end else if (s_q.div != HALF_LAST) begin
			s_d.div = s_q.div + 8'h01;
		end else begin
			s_d.div = 8'h00;
			if (!s_q.sck) begin
				s_d.sck = 1'b1;
				s_d.rxSh = {s_q.rxSh[6:0], flashMiso};
			end else begin
				s_d.sck = 1'b0;
				if (s_q.bits == BITS_LAST) begin
					s_d.busy = 1'b0;
					s_d.done = 1'b1;
				end else begin
					s_d.bits = s_q.bits + 4'h1;
					s_d.mosi = s_q.txSh[7];
					s_d.txSh = {s_q.txSh[6:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign req.done = s_q.done;
	assign req.rxByte = s_q.rxSh;
	assign flashSck = s_q.sck;
	assign flashMosi = s_q.mosi;
endmodule

// [tb/tdc_regs_sva.sv]
// checker: command pulses, bus answers and interrupt relations of the register bank
`timescale 1ns/1ps
module tdc_regs_sva
	import tdc_regs_pkg::*;
(
	// clock, reset and bus
	input wire logic ref_clk, rst, busRead, busWrite, busAck, iackReq, extTrigger,
	input wire logic [23:0] busAddr,
	input wire logic [31:0] busWdata, busRdata, injectData,
	input wire logic [2:0] iackLevel, irqLevel,
	// block outputs
	input wire logic irqRequest, triggerPulse, moduleReset, clearPulse, tdcGlobalReset,
	input wire logic eventReset, injectValid
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	clear_both_a: assert property (clearPulse |-> tdcGlobalReset)
		else $error("clear pulse without tdc reset");
	clear_cause_a: assert property (clearPulse |-> $past(busWrite)
		&& $past(busAddr[15:0]) == OFF_SW_CLEAR)
		else $error("clear pulse without its write");
	evt_cause_a: assert property (eventReset |-> $past(busWrite)
		&& $past(busAddr[15:0]) == OFF_EVENT_RESET)
		else $error("event reset without its write");
	ext_trig_a: assert property (extTrigger |=> triggerPulse)
		else $error("external trigger not passed on");
	trig_cause_a: assert property (triggerPulse |-> $past(extTrigger)
		|| ($past(busWrite) && $past(busAddr[15:0]) == OFF_TRIGGER))
		else $error("trigger without a cause");
	mod_reset_a: assert property (moduleReset |-> busAck
		&& $past(busAddr[15:0]) == OFF_MOD_RESET)
		else $error("module reset without its access");
	irq_level_a: assert property (irqRequest |-> irqLevel != 3'h0)
		else $error("interrupt requested at level zero");
	inject_word_a: assert property (injectValid |-> $past(busWrite)
		&& $past(busAddr[15:0]) == OFF_INJECT && injectData == $past(busWdata))
		else $error("injected word not the written one");
	iack_ack_a: assert property (iackReq && iackLevel == irqLevel && irqLevel != 3'h0
		|=> busAck)
		else $error("acknowledge cycle not answered");

	cover property (irqRequest);
	cover property (injectValid);
	cover property (moduleReset);
endmodule

bind tdc_register_bank tdc_regs_sva chk (.ref_clk, .rst, .busRead, .busWrite, .busAck,
	.iackReq, .extTrigger, .busAddr, .busWdata, .busRdata, .injectData, .iackLevel,
	.irqLevel, .irqRequest, .triggerPulse, .moduleReset, .clearPulse, .tdcGlobalReset,
	.eventReset, .injectValid);

// [tb/flash_model.sv]
// partner: serial flash that records each byte and answers a fixed byte
`timescale 1ns/1ps
module flash_model #(
	parameter logic [7:0] REPLY = 8'ha5
)(
	// serial pins
	input wire logic csN,
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	// last byte taken in
	output logic [7:0] got
);
	logic [7:0] sh;
	logic last;
	initial begin
		sh = REPLY;
		got = 8'h00;
		last = 1'b0;
	end
	// mode 0: take on rising clock, move answer on falling clock
	always @(posedge sck) if (!csN) got = {got[6:0], mosi};
	always @(negedge sck) if (!csN) sh = {sh[6:0], sh[7]};
	always @(negedge csN) sh = REPLY;
	always @(posedge csN) last = sh[7];
	// deselected output floats: show the inverse so a stale bit never passes
	always_comb miso = csN ? ~last : sh[7];
endmodule

// [tb/testbench.sv]
// testbench: scenario tasks for the tdc register bank with a serial flash model
`timescale 1ns/1ps
module testbench;
	import tdc_regs_pkg::*;
	logic ref_clk, rst, busRead, busWrite, busAck, iackReq, irqRequest, extTrigger, trgMatch;
	logic triggerPulse, moduleReset, clearPulse, tdcGlobalReset, eventReset, tdcDataBlock;
	logic injectValid, ctrlReadOk, ctrlWriteOk, ctrlOpcodeWrite, ctrlOpcodeRead, ack;
	logic flashCsN, flashSck, flashMosi, flashMiso;
	logic [7:0] baseSwitch, base, flashGot, blockEventCount;
	logic [4:0] slotPositionCode;
	logic [2:0] iackLevel, irqLevel;
	logic [23:0] busAddr;
	logic [31:0] busWdata, busRdata, injectData, q;
	logic [15:0] bufferWords, eventsHeld, ctrlOpcodeIn, ctrlOpcodeOut, chainControl, outputSelect;
	int fail_count = 0;
	int tests_run = 0;
	int nEvRst = 0;
	int nInj = 0;
	int nClr = 0;
	int nMod = 0;
	int nTrig = 0;
	int nOpW = 0;
	int nOpR = 0;

	tdc_register_bank uut (.ref_clk, .rst, .baseSwitch, .busRead, .busWrite, .busAddr,
		.busWdata, .busAck, .busRdata, .iackReq, .iackLevel, .irqRequest, .irqLevel,
		.extTrigger, .trgMatch, .bufferWords, .eventsHeld, .triggerPulse, .moduleReset,
		.clearPulse, .tdcGlobalReset, .eventReset, .tdcDataBlock, .injectValid, .injectData,
		.slotPositionCode, .blockEventCount, .chainControl, .outputSelect, .ctrlReadOk,
		.ctrlWriteOk, .ctrlOpcodeIn, .ctrlOpcodeWrite, .ctrlOpcodeRead, .ctrlOpcodeOut,
		.flashCsN, .flashSck, .flashMosi, .flashMiso);
	flash_model fm (.csN(flashCsN), .sck(flashSck), .mosi(flashMosi), .miso(flashMiso),
		.got(flashGot));

	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		nEvRst += (eventReset === 1'b1);
		nInj += (injectValid === 1'b1);
		nClr += (clearPulse === 1'b1 && tdcGlobalReset === 1'b1);
		nMod += (moduleReset === 1'b1);
		nTrig += (triggerPulse === 1'b1);
		nOpW += (ctrlOpcodeWrite === 1'b1);
		nOpR += (ctrlOpcodeRead === 1'b1);
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: saw %h expected %h", $time, got, exp);
		end
	endtask
	// m: 0 read, 1 write, 2 acknowledge cycle (level in d)
	task automatic bus(input int m, input logic [7:0] b, input logic [15:0] off,
		input logic [31:0] d);
		@(posedge ref_clk);
		busRead <= (m == 0);
		busWrite <= (m == 1);
		iackReq <= (m == 2);
		iackLevel <= d[2:0];
		busAddr <= {b, off};
		busWdata <= d;
		@(posedge ref_clk);
		busRead <= 1'b0;
		busWrite <= 1'b0;
		iackReq <= 1'b0;
		ack = 1'b0;
		q = 32'h0;
		for (int n = 0; n < 200 && !ack; n++) begin
			@(negedge ref_clk);
			if (busAck === 1'b1) begin
				ack = 1'b1;
				q = busRdata;
			end
		end
	endtask
	task automatic wr(input logic [15:0] off, input logic [31:0] d);
		bus(1, base, off, d);
	endtask
	task automatic rd(input logic [15:0] off);
		bus(0, base, off, 32'h0);
	endtask
	task automatic setw(input logic [15:0] v);
		@(posedge ref_clk) bufferWords <= v;
		repeat (2) @(posedge ref_clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_defaults;
		logic [15:0] offs [10] = '{OFF_IRQ_LEVEL, OFF_IRQ_VECTOR, OFF_SLOT, OFF_MCAST_BASE,
			OFF_FILL_THR, OFF_BLOCK_EVENTS, OFF_FLASH_SEL, OFF_FW_REV, OFF_RELOC_SEL, 16'h1040};
		logic [31:0] exps [10] = '{32'h0, 32'hdd, 32'h1f, 32'haa, 32'h40, 32'h0, 32'h1, 32'h01,
			32'h0, 32'h0};
		for (int i = 0; i < 10; i++) begin
			rd(offs[i]);
			chk(q, exps[i]);
		end
		chk({ack, flashCsN, slotPositionCode}, 7'h7f);
		$display("done: defaults");
	endtask
	task automatic t_rw;
		wr(OFF_SCRATCH_WIDE, 32'hdeadbeef);
		rd(OFF_SCRATCH_WIDE);
		chk(q, 32'hdeadbeef);
		wr(OFF_SCRATCH_NARROW, 32'h1234abcd);
		rd(OFF_SCRATCH_NARROW);
		chk(q, 32'h0000abcd);
		wr(OFF_IRQ_LEVEL, 32'hfffd);
		rd(OFF_IRQ_LEVEL);
		chk(q, 32'h5);
		chk(irqLevel, 3'h5);
		wr(OFF_IRQ_VECTOR, 32'h1234);
		wr(OFF_FILL_THR, 32'hffff);
		rd(OFF_FILL_THR);
		chk(q, 32'h7fdf);
		wr(OFF_BLOCK_EVENTS, 32'h01ff);
		rd(OFF_BLOCK_EVENTS);
		chk({q[7:0], blockEventCount}, 16'hffff);
		wr(OFF_SLOT, 32'h5);
		chk(slotPositionCode, 5'h05);
		$display("done: read and write");
	endtask
	task automatic t_fill;
		wr(OFF_FILL_THR, 32'h10);
		setw(16'h000f);
		rd(OFF_STATUS);
		chk({q[1], irqRequest}, 2'b00);
		setw(16'h0010);
		rd(OFF_STATUS);
		chk({q[1], irqRequest}, 2'b11);
		bus(2, base, 16'h0, 32'h5);
		chk({ack, q[7:0]}, 9'h134);
		bus(2, base, 16'h0, 32'h2);
		chk(ack, 1'b0);
		wr(OFF_IRQ_LEVEL, 32'h0);
		chk(irqRequest, 1'b0);
		setw(16'h000f);
		rd(OFF_STATUS);
		chk(q[1], 1'b0);
		$display("done: almost full");
	endtask
	task automatic t_inject;
		wr(OFF_CONTROL, 32'h100);
		chk(tdcDataBlock, 1'b1);
		wr(OFF_INJECT, 32'hcafe0001);
		chk(injectData, 32'hcafe0001);
		wr(OFF_CONTROL, 32'h0);
		wr(OFF_INJECT, 32'h2);
		rd(OFF_CONTROL);
		chk(nInj, 32'd1);
		chk(tdcDataBlock, 1'b0);
		$display("done: injection");
	endtask
	task automatic t_reloc;
		wr(OFF_RELOC_ADDR, 32'h34);
		rd(OFF_RELOC_ADDR);
		chk(q, 32'h34);
		wr(OFF_RELOC_SEL, 32'h1);
		rd(OFF_SCRATCH_WIDE);
		chk(ack, 1'b0);
		base = 8'h34;
		rd(OFF_SCRATCH_WIDE);
		chk(q, 32'hdeadbeef);
		bus(1, 8'haa, OFF_BLOCK_EVENTS, 32'h9);
		rd(OFF_BLOCK_EVENTS);
		chk(q, 32'h9);
		rd(OFF_MOD_RESET);
		base = 8'h12;
		rd(OFF_SLOT);
		chk(q, 32'h1f);
		$display("done: relocation");
	endtask
	task automatic t_commands;
		wr(OFF_SCRATCH_NARROW, 32'h5a5a);
		wr(OFF_IRQ_VECTOR, 32'h77);
		@(posedge ref_clk) trgMatch <= 1'b1;
		for (int i = 0; i < 3; i++) wr(OFF_TRIGGER, 32'h0);
		@(posedge ref_clk) extTrigger <= 1'b1;
		@(posedge ref_clk) extTrigger <= 1'b0;
		rd(OFF_TRIG_COUNT);
		chk(q, 32'h4);
		@(posedge ref_clk) trgMatch <= 1'b0;
		wr(OFF_TRIGGER, 32'h0);
		rd(OFF_TRIG_COUNT);
		chk(q, 32'h4);
		chk(nTrig, 32'd5);
		wr(OFF_EVENT_RESET, 32'h0);
		wr(OFF_SW_CLEAR, 32'h0);
		rd(OFF_TRIG_COUNT);
		chk(q, 32'h0);
		chk(nEvRst, 32'd1);
		chk(nClr, 32'd1);
		rd(OFF_SCRATCH_NARROW);
		chk(q, 32'h5a5a);
		rd(OFF_EVENTS_HELD);
		chk(q, 32'h7);
		rd(OFF_MOD_RESET);
		chk(ack, 1'b1);
		rd(OFF_IRQ_VECTOR);
		chk(q, 32'hdd);
		chk(nMod, 32'd2);
		$display("done: commands");
	endtask
	task automatic t_flash;
		wr(OFF_FLASH_SEL, 32'h0);
		chk(flashCsN, 1'b0);
		wr(OFF_FLASH_DATA, 32'h5a);
		chk({ack, flashGot}, 9'h15a);
		rd(OFF_FLASH_DATA);
		chk(q[7:0], 8'ha5);
		wr(OFF_FLASH_SEL, 32'h1);
		chk(flashCsN, 1'b1);
		rd(OFF_HANDSHAKE);
		chk(q[1:0], 2'b01);
		wr(OFF_OPCODE, 32'h1234);
		chk(ctrlOpcodeOut, 16'h1234);
		// the opcode may only be read once the controller flags it readable
		@(posedge ref_clk) ctrlReadOk <= 1'b1;
		rd(OFF_HANDSHAKE);
		chk(q[1:0], 2'b11);
		rd(OFF_OPCODE);
		chk(q, 32'hbeef);
		@(negedge ref_clk);
		chk(nOpW, 32'd1);
		chk(nOpR, 32'd1);
		$display("done: flash and controller");
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		{busRead, busWrite, iackReq, extTrigger, trgMatch, ctrlReadOk} = 6'h0;
		{iackLevel, busAddr, busWdata, bufferWords} = 75'h0;
		ctrlWriteOk = 1'b1;
		ctrlOpcodeIn = 16'hbeef;
		eventsHeld = 16'h0007;
		baseSwitch = 8'h12;
		base = 8'h12;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		t_defaults();
		t_rw();
		t_fill();
		t_inject();
		t_reloc();
		t_commands();
		t_flash();
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		end_sim();
	end
endmodule
